//--- hw/shb_pkg.sv
// package for the stream header builder: register map, field layouts, constants
package shb_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_VLAN_TPID = 8'h04;
  localparam logic [7:0] REG_ETYPE = 8'h08;
  localparam logic [7:0] REG_IP_A = 8'h0C;
  localparam logic [7:0] REG_IP_B = 8'h10;
  localparam logic [7:0] REG_IP_C = 8'h14;
  localparam logic [7:0] REG_SRC_IP = 8'h18;
  localparam logic [7:0] REG_DST_IP = 8'h1C;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_PAYLEN = 8'h24;
  localparam logic [7:0] REG_VLAN_TCI0 = 8'h40;
  // control fields
  localparam int CTRL_L3_LSB = 0;
  localparam int CTRL_LLC = 2;
  localparam int CTRL_SNAP = 3;
  localparam int CTRL_AUTOID = 4;
  localparam int CTRL_HIGHRATE = 5;
  localparam int CTRL_LVL_LSB = 8;
  localparam int CTRL_CTL16 = 12;
  // ip_c fields
  localparam int FLG_DF = 14;
  localparam int FLG_MF = 13;
  // layer 3 selector codes
  localparam logic [1:0] L3_NONE = 2'h0;
  localparam logic [1:0] L3_IPV4 = 2'h1;
  localparam logic [1:0] L3_IPV6 = 2'h2;
  // ethertypes
  localparam logic [15:0] ET_IPV4 = 16'h0800;
  localparam logic [15:0] ET_IPV6 = 16'h86DD;
  localparam logic [15:0] TPID_0 = 16'h8100;
  localparam logic [15:0] TPID_1 = 16'h88A8;
  localparam logic [15:0] TPID_2 = 16'h9100;
  localparam logic [15:0] TPID_3 = 16'h9200;
  localparam logic [15:0] ET_USER_MIN = 16'h05DD;
  localparam logic [15:0] ET_USER_MAX = 16'hFFFF;
  // llc / snap
  localparam logic [7:0] SAP_SNAP = 8'hAA;
  localparam logic [7:0] SAP_IP = 8'h06;
  localparam logic [7:0] SAP_NONE = 8'hFE;
  localparam logic [7:0] LLC_UI = 8'h03;
  localparam logic [23:0] SNAP_PID = 24'h000000;
  // ipv4
  localparam logic [3:0] IP_VER = 4'h4;
  localparam logic [3:0] IP_IHL = 4'h5;
  localparam logic [15:0] IP_HDR_BYTES = 16'h0014;
  localparam logic [7:0] TTL_RST = 8'h20;
  localparam logic [7:0] PROTO_RST = 8'hFD;
  localparam logic [7:0] MAX_LVL = 8'h08;
  localparam logic [7:0] MAX_LVL_HI = 8'h04;
  localparam int HDR_BYTES = 90;
endpackage

//--- hw/shb_top.sv
// stream header builder: axi4-lite config and byte-serial header emitter
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Function
// - non-final vlan tags use one of four tpids
// - innermost ethertype auto from ip layer
// - user ethertype only within allowed range
// - llc sap and control derived from upper
// - saps one octet, control one or two
// - snap protocol id zero, ethertype from upper
// - snap only with llc, not high rate
// - auto increment disabled at high rate
// - version four, header length five words
// - ipv4 fields in standard order
// - programmed tos octet inserted
// - total length computed and readable
// - identifier increments per frame when enabled
// - enabled flags sent as one
// - reserved flag always zero
// - ttl programmed, default thirty two
// - each vlan adds tci and ethertype
// - up to eight vlans, four high rate
// - protocol octet names upper protocol
module shb_top (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frame_start_i,
  input wire logic tx_ready_i,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  output logic tx_last_o,
  output logic busy_o
);
  // ==========================================================
  // reset synchroniser
  logic [1:0] rst_sync_ff;
  logic rstn;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) rst_sync_ff <= 2'h0;
    else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rstn = rst_sync_ff[1];

  // ==========================================================
  // register file
  logic [15:0] ctrl_ff;
  logic [7:0] tpid_sel_ff;
  logic [15:0] etype_ff;
  logic [31:0] ip_a_ff, ip_b_ff, ip_c_ff, src_ip_ff, dst_ip_ff;
  logic [15:0] paylen_ff;
  logic [15:0] tci_ff [8];
  logic [15:0] id_ff;
  logic etype_err_ff;
  logic aw_ff, w_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] l3;
  logic [3:0] lvl;
  logic hi_rate, snap_en, autoid_en;
  assign l3 = ctrl_ff[shb_pkg::CTRL_L3_LSB+:2];
  assign hi_rate = ctrl_ff[shb_pkg::CTRL_HIGHRATE];
  assign snap_en = ctrl_ff[shb_pkg::CTRL_SNAP] & ctrl_ff[shb_pkg::CTRL_LLC] & ~hi_rate;
  assign autoid_en = ctrl_ff[shb_pkg::CTRL_AUTOID] & ~hi_rate;
  // level count clamped to eight, or four at the highest rate
  always_comb begin
    lvl = ctrl_ff[shb_pkg::CTRL_LVL_LSB+:4];
    if (hi_rate && {4'h0, lvl} > shb_pkg::MAX_LVL_HI) lvl = shb_pkg::MAX_LVL_HI[3:0];
    else if ({4'h0, lvl} > shb_pkg::MAX_LVL) lvl = shb_pkg::MAX_LVL[3:0];
  end

  // write channel: address and data accepted in either order
  logic do_wr;
  assign s_axi_awready = ~aw_ff & ~s_axi_bvalid;
  assign s_axi_wready = ~w_ff & ~s_axi_bvalid;
  assign do_wr = aw_ff & w_ff & ~s_axi_bvalid;
  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_bresp = 2'h0;

  // byte-lane merge helper
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    for (int i = 0; i < 4; i++) if (s[i]) o[i*8+:8] = d[i*8+:8];
    return o;
  endfunction

  logic [15:0] wr_et;
  assign wr_et = 16'(merge({16'h0, etype_ff}, wdata_ff, wstrb_ff));
  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= 16'h0;
      tpid_sel_ff <= 8'h00;
      etype_ff <= shb_pkg::ET_USER_MIN;
      ip_a_ff <= 32'h0;
      ip_b_ff <= 32'h0;
      ip_c_ff <= {shb_pkg::PROTO_RST, shb_pkg::TTL_RST, 16'h0000};
      src_ip_ff <= 32'h0;
      dst_ip_ff <= 32'h0;
      paylen_ff <= 16'h0026;
      etype_err_ff <= 1'b0;
      for (int i = 0; i < 8; i++) tci_ff[i] <= 16'h0;
    end else if (do_wr) begin
      unique case (awaddr_ff)
        shb_pkg::REG_CTRL: ctrl_ff <= 16'(merge({16'h0, ctrl_ff}, wdata_ff, wstrb_ff));
        shb_pkg::REG_VLAN_TPID: tpid_sel_ff <= 8'(merge({24'h0, tpid_sel_ff}, wdata_ff, wstrb_ff));
        shb_pkg::REG_ETYPE: begin
          // out-of-range values refused, old value kept
          if (wr_et >= shb_pkg::ET_USER_MIN && wr_et <= shb_pkg::ET_USER_MAX) begin
            etype_ff <= wr_et;
            etype_err_ff <= 1'b0;
          end else etype_err_ff <= 1'b1;
        end
        shb_pkg::REG_IP_A: ip_a_ff <= merge(ip_a_ff, wdata_ff, wstrb_ff);
        shb_pkg::REG_IP_B: ip_b_ff <= merge(ip_b_ff, wdata_ff, wstrb_ff);
        shb_pkg::REG_IP_C: ip_c_ff <= merge(ip_c_ff, wdata_ff, wstrb_ff);
        shb_pkg::REG_SRC_IP: src_ip_ff <= merge(src_ip_ff, wdata_ff, wstrb_ff);
        shb_pkg::REG_DST_IP: dst_ip_ff <= merge(dst_ip_ff, wdata_ff, wstrb_ff);
        shb_pkg::REG_PAYLEN: paylen_ff <= 16'(merge({16'h0, paylen_ff}, wdata_ff, wstrb_ff));
        default: begin
          if (awaddr_ff[7:5] == 3'h2) tci_ff[awaddr_ff[4:2]] <= 16'(merge({16'h0, tci_ff[awaddr_ff[4:2]]},
            wdata_ff, wstrb_ff));
        end
      endcase
    end
  end

  // derived header fields
  logic [15:0] tot_len;
  logic [15:0] inner_et;
  logic [15:0] upper_et;
  assign tot_len = shb_pkg::IP_HDR_BYTES + paylen_ff;
  assign upper_et = (l3 == shb_pkg::L3_IPV6) ? shb_pkg::ET_IPV6 : shb_pkg::ET_IPV4;
  assign inner_et = (l3 == shb_pkg::L3_NONE) ? etype_ff : upper_et;

  // read channel
  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      unique case (s_axi_araddr)
        shb_pkg::REG_CTRL: s_axi_rdata <= {16'h0, ctrl_ff};
        shb_pkg::REG_VLAN_TPID: s_axi_rdata <= {24'h0, tpid_sel_ff};
        shb_pkg::REG_ETYPE: s_axi_rdata <= {16'h0, etype_ff};
        shb_pkg::REG_IP_A: s_axi_rdata <= ip_a_ff;
        shb_pkg::REG_IP_B: s_axi_rdata <= ip_b_ff;
        shb_pkg::REG_IP_C: s_axi_rdata <= ip_c_ff;
        shb_pkg::REG_SRC_IP: s_axi_rdata <= src_ip_ff;
        shb_pkg::REG_DST_IP: s_axi_rdata <= dst_ip_ff;
        shb_pkg::REG_STATUS: s_axi_rdata <= {tot_len, id_ff};
        shb_pkg::REG_PAYLEN: s_axi_rdata <= {15'h0, etype_err_ff, paylen_ff};
        default: begin
          if (s_axi_araddr[7:5] == 3'h2) s_axi_rdata <= {16'h0, tci_ff[s_axi_araddr[4:2]]};
          else begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
          end
        end
      endcase
    end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end
  assign s_axi_arready = ~s_axi_rvalid;

  // ==========================================================
  // header image: snapshot at frame start so fields stay coherent
  logic [8*shb_pkg::HDR_BYTES-1:0] img_ff;
  logic [6:0] len_ff, pos_ff;
  logic run_ff;
  logic [15:0] ip_w [10];
  logic [16:0] s1;
  logic [15:0] csum;
  logic [15:0] tpid_of [4];
  logic [7:0] dsap;
  assign tpid_of[0] = shb_pkg::TPID_0;
  assign tpid_of[1] = shb_pkg::TPID_1;
  assign tpid_of[2] = shb_pkg::TPID_2;
  assign tpid_of[3] = shb_pkg::TPID_3;
  // ipv4 words in standard order; reserved flag forced to zero
  always_comb begin
    ip_w[0] = {shb_pkg::IP_VER, shb_pkg::IP_IHL, ip_a_ff[7:0]};
    ip_w[1] = tot_len;
    ip_w[2] = id_ff;
    ip_w[3] = {1'b0, ip_c_ff[shb_pkg::FLG_DF], ip_c_ff[shb_pkg::FLG_MF], ip_c_ff[12:0]};
    ip_w[4] = {ip_c_ff[23:16], ip_c_ff[31:24]};
    ip_w[5] = src_ip_ff[31:16];
    ip_w[6] = src_ip_ff[15:0];
    ip_w[7] = dst_ip_ff[31:16];
    ip_w[8] = dst_ip_ff[15:0];
    ip_w[9] = 16'h0;
    csum = 16'h0;
    s1 = 17'h0;
    for (int i = 0; i < 9; i++) begin
      s1 = {1'b0, csum} + {1'b0, ip_w[i]};
      csum = s1[15:0] + {15'h0, s1[16]};
    end
    csum = ~csum;
    dsap = snap_en ? shb_pkg::SAP_SNAP : ((l3 == shb_pkg::L3_NONE) ? shb_pkg::SAP_NONE : shb_pkg::SAP_IP);
  end

  // serialise the header byte by byte, valid/ready toward the link
  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      img_ff <= '0;
      len_ff <= 7'h0;
      pos_ff <= 7'h0;
      run_ff <= 1'b0;
      id_ff <= 16'h0;
    end else if (!run_ff) begin
      if (frame_start_i) begin
        logic [7:0] n;
        n = 8'h0;
        img_ff <= '0;
        for (int i = 0; i < 8; i++) if (i < int'(lvl)) begin
          img_ff[8*shb_pkg::HDR_BYTES-1-8*n-:32] <= {tci_ff[i], (i == int'(lvl) - 1) ? inner_et :
            tpid_of[tpid_sel_ff[i%4*2+:2]]};
          n = n + 8'h04;
        end
        if (ctrl_ff[shb_pkg::CTRL_LLC]) begin
          img_ff[8*shb_pkg::HDR_BYTES-1-8*n-:32] <= {dsap, dsap, shb_pkg::LLC_UI, 8'h00};
          n = n + (ctrl_ff[shb_pkg::CTRL_CTL16] ? 8'h04 : 8'h03);
          if (snap_en) begin
            img_ff[8*shb_pkg::HDR_BYTES-1-8*n-:40] <= {shb_pkg::SNAP_PID, upper_et};
            n = n + 8'h05;
          end
        end
        if (l3 == shb_pkg::L3_IPV4) begin
          img_ff[8*shb_pkg::HDR_BYTES-1-8*n-:160] <= {ip_w[0], ip_w[1], ip_w[2], ip_w[3], ip_w[4], csum,
            ip_w[5], ip_w[6], ip_w[7], ip_w[8]};
          n = n + 8'h14;
        end
        len_ff <= n[6:0];
        pos_ff <= 7'h0;
        run_ff <= (n != 8'h0);
        if (autoid_en) id_ff <= id_ff + 16'h0001;
        else id_ff <= ip_b_ff[15:0];
      end else if (!autoid_en) id_ff <= ip_b_ff[15:0];
    end else if (tx_ready_i) begin
      pos_ff <= pos_ff + 7'h01;
      if (pos_ff + 7'h01 == len_ff) run_ff <= 1'b0;
    end
  end
  assign tx_valid_o = run_ff;
  assign tx_data_o = img_ff[8*shb_pkg::HDR_BYTES-1-8*pos_ff-:8];
  assign tx_last_o = run_ff & (pos_ff + 7'h01 == len_ff);
  assign busy_o = run_ff;

  // ==========================================================
  // checks
  a_reserved_flag_zero: assert property (@(posedge clk_i) disable iff (!rstn) ip_w[3][15] == 1'b0)
    else $error("reserved flag set");
  a_version_ihl: assert property (@(posedge clk_i) disable iff (!rstn) ip_w[0][15:8] == 8'h45)
    else $error("bad version or ihl");
  a_snap_needs_llc: assert property (@(posedge clk_i) disable iff (!rstn)
    snap_en |-> ctrl_ff[shb_pkg::CTRL_LLC] && !hi_rate) else $error("snap without llc");
  a_autoid_step: assert property (@(posedge clk_i) disable iff (!rstn)
    (!run_ff && frame_start_i && autoid_en) |=> id_ff == $past(id_ff) + 16'h0001) else $error("id no step");
  a_etype_range: assert property (@(posedge clk_i) disable iff (!rstn)
    etype_ff >= shb_pkg::ET_USER_MIN) else $error("etype out of range");
  a_lvl_limit: assert property (@(posedge clk_i) disable iff (!rstn)
    hi_rate |-> lvl <= 4'h4) else $error("too many levels");
  a_inner_auto: assert property (@(posedge clk_i) disable iff (!rstn)
    (l3 == shb_pkg::L3_IPV4) |-> inner_et == shb_pkg::ET_IPV4) else $error("inner ethertype wrong");
  a_totlen: assert property (@(posedge clk_i) disable iff (!rstn)
    tot_len == paylen_ff + 16'h0014) else $error("total length wrong");
endmodule

//--- testbench/shb_link_sink.sv
// link-side partner model: takes header bytes, can stall
`timescale 1ns/1ps
module shb_link_sink (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic [7:0] data_i,
  input wire logic valid_i,
  input wire logic last_i,
  output logic ready_o
);
  logic [7:0] q[$];
  int frames = 0;
  logic [1:0] ph_ff = 2'h0;
  // ==========================================
  // byte capture
  // slow mode takes one byte in four, so the sender must hold its byte
  always @(posedge clk_i) begin
    ph_ff <= ph_ff + 2'h1;
    if (valid_i && ready_o) begin
      q.push_back(data_i);
      if (last_i) frames <= frames + 1;
    end
  end
  assign ready_o = !slow_i || (ph_ff == 2'h3);
endmodule

//--- testbench/stream_header_builder_tb.sv
// self-checking bench for the stream header builder
`timescale 1ns/1ps
module stream_header_builder_tb;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [7:0] tps;
    logic [31:0] ipc;
    logic [7:0] len;
  } shb_row_t;
  localparam logic [7:0] TOS = 8'h5A;
  localparam logic [15:0] FID = 16'hABCD;
  localparam logic [15:0] PL = 16'h0100;
  localparam logic [31:0] SIP = 32'hC0A80001;
  localparam logic [31:0] DIP = 32'h0A000002;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, tdata;
  logic [31:0] wdata = 32'h0, rdata, ipc, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tvalid, tlast, busy, tready;
  logic start = 1'b0, slow = 1'b0;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] ctrl, fid, uet;
  logic [7:0] tps;
  logic [7:0] e[$];
  logic [15:0] tp[4] = '{shb_pkg::TPID_0, shb_pkg::TPID_1, shb_pkg::TPID_2, shb_pkg::TPID_3};
  int failures = 0, n_compared = 0;
  // ordinary frames: control, tag types, ip word, expected byte count
  shb_row_t rows[6] = '{'{16'h0201, 8'h01, 32'h0640_8000, 8'h1C}, '{16'h0404, 8'h38, 32'h1120_0000, 8'h13},
    '{16'h110D, 8'h00, 32'h0120_7FFF, 8'h21}, '{16'h0805, 8'hE4, 32'h06FF_2001, 8'h37},
    '{16'h012D, 8'h00, 32'h1120_4000, 8'h1B}, '{16'h0202, 8'h02, 32'h0000_0000, 8'h08}};
  // ==========================================
  // design and link partner
  shb_top shb_top_i (.clk_i(clk_i), .resetn_i(resetn_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .frame_start_i(start),
    .tx_ready_i(tready), .tx_data_o(tdata), .tx_valid_o(tvalid), .tx_last_o(tlast), .busy_o(busy));
  shb_link_sink shb_link_sink_i (.clk_i(clk_i), .slow_i(slow), .data_i(tdata), .valid_i(tvalid),
    .last_i(tlast), .ready_o(tready));
  // ==========================================
  // clock and watchdog
  initial forever #2.5 clk_i = ~clk_i;
  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    final_report();
  end
  // ==========================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // handshakes judged at the falling edge, released after the rising one
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    int t;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    hb = 1'b0;
    t = 0;
    while (!hb && t < 100) begin
      @(negedge clk_i);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      @(posedge clk_i);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      t++;
    end
    bready <= 1'b0;
    if (!hb) failures++;
    // one idle edge, so a following call never raises bready in this step
    @(posedge clk_i);
  endtask
  task automatic rdreg(input logic [7:0] a);
    logic ha, h;
    int t;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    h = 1'b0;
    t = 0;
    while (!h && t < 100) begin
      @(negedge clk_i);
      ha = arvalid && arready;
      h = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge clk_i);
      if (ha) arvalid <= 1'b0;
      t++;
    end
    rready <= 1'b0;
    if (!h) failures++;
    // one idle edge, so a following call never raises rready in this step
    @(posedge clk_i);
  endtask
  function automatic logic [15:0] inner();
    if (ctrl[1:0] == shb_pkg::L3_IPV4) return shb_pkg::ET_IPV4;
    if (ctrl[1:0] == shb_pkg::L3_IPV6) return shb_pkg::ET_IPV6;
    return uet;
  endfunction
  function automatic void put16(input logic [15:0] v);
    e.push_back(v[15:8]);
    e.push_back(v[7:0]);
  endfunction
  // expected header, most significant byte first
  function automatic void build();
    logic [15:0] w[10];
    logic [31:0] s;
    logic [7:0] sap;
    logic snap;
    int n;
    n = int'(ctrl[11:8]);
    // level count limited to four at the high rate, eight otherwise
    if (ctrl[5] && n > 4) n = 4;
    if (n > 8) n = 8;
    snap = ctrl[3] && !ctrl[5];
    e.delete();
    for (int i = 0; i < n; i++) begin
      put16(16'hE000 + 16'(i));
      put16(i == n - 1 ? inner() : tp[tps[2*(i%4)+:2]]);
    end
    sap = snap ? shb_pkg::SAP_SNAP : (ctrl[1:0] == 2'h1 ? shb_pkg::SAP_IP : shb_pkg::SAP_NONE);
    if (ctrl[2]) begin
      e.push_back(sap);
      e.push_back(sap);
      e.push_back(8'h03);
      if (ctrl[12]) e.push_back(8'h00);
      if (snap) begin
        put16(16'h0000);
        e.push_back(8'h00);
        put16(inner());
      end
    end
    if (ctrl[1:0] == 2'h1) begin
      w = '{{8'h45, TOS}, 16'h0014 + PL, fid, {1'b0, ipc[14:0]}, {ipc[23:16], ipc[31:24]}, 16'h0000,
        SIP[31:16], SIP[15:0], DIP[31:16], DIP[15:0]};
      s = 32'h0;
      foreach (w[i]) s += {16'h0, w[i]};
      repeat (2) s = {16'h0, s[15:0]} + {16'h0, s[31:16]};
      w[5] = ~s[15:0];
      foreach (w[i]) put16(w[i]);
    end
  endfunction
  // start one frame and wait, bounded, until the link has it all
  task automatic send_cmp(input logic [7:0] len);
    int f, t;
    f = shb_link_sink_i.frames;
    shb_link_sink_i.q.delete();
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    t = 0;
    while (shb_link_sink_i.frames == f && t < 3000) begin
      @(posedge clk_i);
      t++;
    end
    if (t >= 3000) failures++;
    @(posedge clk_i);
    build();
    if (len != 8'h00) chk(shb_link_sink_i.q.size(), len);
    foreach (e[i]) chk(shb_link_sink_i.q[i], e[i]);
    chk(busy, 1'b0);
  endtask
  task automatic final_report();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    fid = FID;
    uet = 16'hFFFF;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rdreg(shb_pkg::REG_IP_C);
    chk(rd, 32'hFD20_0000);
    rdreg(shb_pkg::REG_STATUS);
    chk(rd[31:16], 16'h003A);
    wr(shb_pkg::REG_IP_A, {24'h0, TOS});
    wr(shb_pkg::REG_IP_B, {16'h0, FID});
    wr(shb_pkg::REG_SRC_IP, SIP);
    wr(shb_pkg::REG_DST_IP, DIP);
    wr(shb_pkg::REG_PAYLEN, {16'h0, PL});
    wr(shb_pkg::REG_ETYPE, {16'h0, uet});
    for (int i = 0; i < 8; i++) wr(shb_pkg::REG_VLAN_TCI0 + 8'(4 * i), 32'h0000_E000 + 32'(i));
    foreach (rows[k]) begin
      ctrl = rows[k].ctrl;
      tps = rows[k].tps;
      ipc = rows[k].ipc;
      slow <= k[0];
      wr(shb_pkg::REG_CTRL, {16'h0, ctrl});
      wr(shb_pkg::REG_VLAN_TPID, {24'h0, tps});
      wr(shb_pkg::REG_IP_C, ipc);
      send_cmp(rows[k].len);
      $display("row %0d done", k);
    end
    rdreg(shb_pkg::REG_STATUS);
    chk(rd[31:16], 16'h0114);
    // refused ethertype keeps the old value and flags the error
    wr(shb_pkg::REG_ETYPE, 32'h0000_05DC);
    rdreg(shb_pkg::REG_ETYPE);
    chk(rd[15:0], 16'hFFFF);
    rdreg(shb_pkg::REG_PAYLEN);
    chk(rd[16], 1'b1);
    wr(shb_pkg::REG_ETYPE, 32'h0000_05DD);
    rdreg(shb_pkg::REG_PAYLEN);
    chk(rd[16], 1'b0);
    uet = 16'h05DD;
    ctrl = 16'h0100;
    wr(shb_pkg::REG_CTRL, 32'h0000_0100);
    send_cmp(8'h04);
    rdreg(8'h30);
    chk(rs, 2'h2);
    $display("refusal tests done");
    // auto identifier steps per frame, checksum follows it
    ctrl = 16'h0111;
    wr(shb_pkg::REG_CTRL, 32'h0000_0111);
    send_cmp(8'h18);
    fid = FID + 16'h0001;
    send_cmp(8'h18);
    fid = FID;
    ctrl = 16'h0831;
    wr(shb_pkg::REG_CTRL, 32'h0000_0831);
    send_cmp(8'h24);
    $display("identifier tests done");
    // mid-run reset brings the registers back to their reset values
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rdreg(shb_pkg::REG_IP_C);
    chk(rd, 32'hFD20_0000);
    rdreg(shb_pkg::REG_STATUS);
    chk(rd[31:16], 16'h003A);
    chk(busy, 1'b0);
    $display("reset tests done");
    final_report();
  end
endmodule
